// ---- design/gpio_pin_function_config.sv ----
// Eight-port GPIO block: registers, pin function mux, pads, interrupts
module gpio_pin_function_config (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic [gpio_pkg::ADDR_W-1:0]   bus_addr,
    input  wire logic [gpio_pkg::DATA_W-1:0]   bus_wdata,
    input  wire logic                          bus_wr,
    input  wire logic                          bus_rd,
    output logic      [gpio_pkg::DATA_W-1:0]   bus_rdata,
    input  wire gpio_pkg::pin_map_t            pin_in,
    output gpio_pkg::pin_map_t                 pin_out,
    output gpio_pkg::pin_map_t                 pin_oe,
    input  wire gpio_pkg::pin_map_t            alt_out,
    input  wire gpio_pkg::pin_map_t            alt_oe,
    output gpio_pkg::pin_map_t                 periph_in,
    output gpio_pkg::code_map_t                alt_code,
    output gpio_pkg::pad_map_t                 pad_cfg,
    output logic                               irq,
    output logic                               adc_trig
);
    typedef struct packed {
        gpio_pkg::pin_map_t  data;
        gpio_pkg::pin_map_t  dir;
        gpio_pkg::pin_map_t  sense;
        gpio_pkg::pin_map_t  both;
        gpio_pkg::pin_map_t  evsel;
        gpio_pkg::pin_map_t  mask;
        gpio_pkg::pin_map_t  status;
        gpio_pkg::pin_map_t  afsel;
        gpio_pkg::pin_map_t  digital_enable_bit;
        gpio_pkg::pin_map_t  analog_mode_select_bit;
        gpio_pkg::pin_map_t  pur;
        gpio_pkg::pin_map_t  pdr;
        gpio_pkg::pin_map_t  odr;
        gpio_pkg::pin_map_t  slr;
        gpio_pkg::pin_map_t  adcen;
        gpio_pkg::pin_map_t  pin_out;
        gpio_pkg::pin_map_t  pin_oe;
        gpio_pkg::drv_map_t  drive;
        gpio_pkg::code_map_t code;
        logic [31:0]         rdata;
        logic                adc_trig;
    } state_s;

    // ------------------------------------------------------------------
    // Reset image
    // ------------------------------------------------------------------
    function automatic state_s reset_state();
        state_s s;
        s       = '0;
        // R13 all other fields clear, pins tri-stated
        // R14 serial pins alternate with code 0x1
        s.afsel = gpio_pkg::AFSEL_RST;
        s.digital_enable_bit   = gpio_pkg::DEN_RST;
        // R15 debug pins pulled up with code 0x3
        s.pur   = gpio_pkg::PUR_RST;
        s.code  = gpio_pkg::PCTL_RST;
        return s;
    endfunction

    localparam state_s RST_STATE = reset_state();

    state_s              s_r;
    state_s              s_nxt;
    gpio_pkg::pin_map_t  din;
    gpio_pkg::pin_map_t  evt;
    logic [2:0]          port_idx;
    logic [11:0]         off;
    logic [7:0]          bmask;
    logic [7:0]          wbyte;
    logic [7:0]          rbyte;
    logic [6:0]          hi_cnt;
    gpio_pkg::drv_e      new_drv;
    logic                out_b;
    logic                oe_b;

    assign port_idx = bus_addr[gpio_pkg::ADDR_W-1:gpio_pkg::PORT_LSB];
    assign off      = bus_addr[gpio_pkg::PORT_LSB-1:0];
    assign bmask    = bus_addr[gpio_pkg::MASK_LSB+7:gpio_pkg::MASK_LSB];
    assign wbyte    = bus_wdata[7:0];

    // Only digital-enabled pins feed peripherals and event logic
    assign din = pin_in & s_r.digital_enable_bit;

    // ------------------------------------------------------------------
    // Per-port event detectors
    // ------------------------------------------------------------------
    // R01 one detector block per port
    for (genvar p = 0; p < gpio_pkg::NPORT; p++) begin : g_port
        gpio_irq_detect #(
            .NPIN (gpio_pkg::NPIN)
        ) u_detect (
            .clk      (clk),
            .sys_rst  (sys_rst),
            .level_in (din[p]),
            .sense    (s_r.sense[p]),
            .both     (s_r.both[p]),
            .evsel    (s_r.evsel[p]),
            .evt      (evt[p])
        );
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt   = s_r;
        rbyte   = 8'h00;
        hi_cnt  = 7'h00;
        new_drv = gpio_pkg::DRV_2MA;
        out_b   = 1'b0;
        oe_b    = 1'b0;

        for (int p = 0; p < gpio_pkg::NPORT; p++) begin
            for (int i = 0; i < gpio_pkg::NPIN; i++) begin
                if (s_r.drive[p][i] == gpio_pkg::DRV_18MA) begin
                    hi_cnt = hi_cnt + 7'h01;
                end
            end
        end

        // Register writes
        if (bus_wr) begin
            if (off < gpio_pkg::OFF_DIR) begin
                // R06 only address-selected bits change
                // R02 new level reaches the pin two edges later
                s_nxt.data[port_idx] = (s_r.data[port_idx] & ~bmask) |
                                       (wbyte & bmask);
            end else begin
                case (off)
                    gpio_pkg::OFF_DIR: begin
                        s_nxt.dir[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_SENSE: begin
                        s_nxt.sense[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_BOTH: begin
                        s_nxt.both[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_EVSEL: begin
                        s_nxt.evsel[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_MASK: begin
                        s_nxt.mask[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_STATUS: begin
                        s_nxt.status[port_idx] = s_r.status[port_idx] &
                                                 ~wbyte;
                    end
                    gpio_pkg::OFF_AFSEL: begin
                        s_nxt.afsel[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_DRIVE: begin
                        // Lowered pins free their slot in the same write
                        for (int i = 0; i < gpio_pkg::NPIN; i++) begin
                            new_drv = gpio_pkg::drv_e'(bus_wdata[2*i +: 2]);
                            if (s_r.drive[port_idx][i] ==
                                gpio_pkg::DRV_18MA &&
                                new_drv != gpio_pkg::DRV_18MA) begin
                                hi_cnt = hi_cnt - 7'h01;
                            end
                        end
                        // R08 refuse an 18 mA pad beyond the limit
                        for (int i = 0; i < gpio_pkg::NPIN; i++) begin
                            new_drv = gpio_pkg::drv_e'(bus_wdata[2*i +: 2]);
                            if (new_drv != gpio_pkg::DRV_18MA) begin
                                s_nxt.drive[port_idx][i] = new_drv;
                            end else if (s_r.drive[port_idx][i] ==
                                         gpio_pkg::DRV_18MA) begin
                                s_nxt.drive[port_idx][i] = new_drv;
                            end else if (hi_cnt <
                                         gpio_pkg::MAX_HI_DRIVE) begin
                                s_nxt.drive[port_idx][i] = new_drv;
                                hi_cnt = hi_cnt + 7'h01;
                            end
                        end
                    end
                    gpio_pkg::OFF_ODR: begin
                        s_nxt.odr[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_PUR: begin
                        s_nxt.pur[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_PDR: begin
                        s_nxt.pdr[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_SLR: begin
                        s_nxt.slr[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_DEN: begin
                        s_nxt.digital_enable_bit[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_ANALOG_MODE_SELECT_BIT: begin
                        s_nxt.analog_mode_select_bit[port_idx] = wbyte;
                    end
                    gpio_pkg::OFF_PCTL: begin
                        // R12 one code field per pin
                        s_nxt.code[port_idx] = bus_wdata;
                    end
                    gpio_pkg::OFF_ADCEN: begin
                        s_nxt.adcen[port_idx] = wbyte;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Set beats a same-cycle clear, so no event is lost
        s_nxt.status = s_nxt.status | evt;

        // R07 any enabled pin event starts the converter
        s_nxt.adc_trig = |(evt & s_r.adcen);

        // Register reads; data stands for one cycle only
        if (bus_rd) begin
            if (off < gpio_pkg::OFF_DIR) begin
                // R06 unselected bits read as zero
                rbyte = ((s_r.dir[port_idx] & s_r.data[port_idx]) |
                         (~s_r.dir[port_idx] & din[port_idx])) & bmask;
                s_nxt.rdata = {24'h000000, rbyte};
            end else begin
                case (off)
                    gpio_pkg::OFF_DIR:
                        s_nxt.rdata = {24'h000000, s_r.dir[port_idx]};
                    gpio_pkg::OFF_SENSE:
                        s_nxt.rdata = {24'h000000, s_r.sense[port_idx]};
                    gpio_pkg::OFF_BOTH:
                        s_nxt.rdata = {24'h000000, s_r.both[port_idx]};
                    gpio_pkg::OFF_EVSEL:
                        s_nxt.rdata = {24'h000000, s_r.evsel[port_idx]};
                    gpio_pkg::OFF_MASK:
                        s_nxt.rdata = {24'h000000, s_r.mask[port_idx]};
                    gpio_pkg::OFF_STATUS:
                        s_nxt.rdata = {24'h000000, s_r.status[port_idx]};
                    gpio_pkg::OFF_MSTAT:
                        s_nxt.rdata = {24'h000000, s_r.status[port_idx] &
                                                   s_r.mask[port_idx]};
                    gpio_pkg::OFF_AFSEL:
                        s_nxt.rdata = {24'h000000, s_r.afsel[port_idx]};
                    gpio_pkg::OFF_DRIVE:
                        s_nxt.rdata = {16'h0000, s_r.drive[port_idx]};
                    gpio_pkg::OFF_ODR:
                        s_nxt.rdata = {24'h000000, s_r.odr[port_idx]};
                    gpio_pkg::OFF_PUR:
                        s_nxt.rdata = {24'h000000, s_r.pur[port_idx]};
                    gpio_pkg::OFF_PDR:
                        s_nxt.rdata = {24'h000000, s_r.pdr[port_idx]};
                    gpio_pkg::OFF_SLR:
                        s_nxt.rdata = {24'h000000, s_r.slr[port_idx]};
                    gpio_pkg::OFF_DEN:
                        s_nxt.rdata = {24'h000000, s_r.digital_enable_bit[port_idx]};
                    gpio_pkg::OFF_ANALOG_MODE_SELECT_BIT:
                        s_nxt.rdata = {24'h000000, s_r.analog_mode_select_bit[port_idx]};
                    gpio_pkg::OFF_PCTL:
                        s_nxt.rdata = s_r.code[port_idx];
                    gpio_pkg::OFF_ADCEN:
                        s_nxt.rdata = {24'h000000, s_r.adcen[port_idx]};
                    default:
                        s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end else begin
            s_nxt.rdata = 32'h0000_0000;
        end

        // Pin drive path
        for (int p = 0; p < gpio_pkg::NPORT; p++) begin
            for (int i = 0; i < gpio_pkg::NPIN; i++) begin
                // R17 GPIO data and direction unless alternate
                // R11 peripheral drive needs alternate select
                out_b = s_r.afsel[p][i] ? alt_out[p][i] : s_r.data[p][i];
                oe_b  = s_r.afsel[p][i] ? alt_oe[p][i] : s_r.dir[p][i];
                // Open drain only ever pulls low
                if (s_r.odr[p][i]) begin
                    oe_b  = oe_b & ~out_b;
                    out_b = 1'b0;
                end
                s_nxt.pin_out[p][i] = out_b;
                // R11 no drive without digital enable
                s_nxt.pin_oe[p][i]  = oe_b & s_r.digital_enable_bit[p][i];
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        // R16 one reset serves power-on and the reset pin
        if (sys_rst) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < gpio_pkg::NPORT; p++) begin
            for (int i = 0; i < gpio_pkg::NPIN; i++) begin
                // R11 code reaches peripherals only when fully selected
                alt_code[p][i] = (s_r.afsel[p][i] & s_r.digital_enable_bit[p][i]) ?
                                 s_r.code[p][i] : 4'h0;
                pad_cfg[p][i].pull_up       = s_r.pur[p][i];
                pad_cfg[p][i].pull_down     = s_r.pdr[p][i];
                pad_cfg[p][i].open_drain    = s_r.odr[p][i];
                // Slew control only applies at 8 mA
                pad_cfg[p][i].slew_ctl      = s_r.slr[p][i] &
                    (s_r.drive[p][i] == gpio_pkg::DRV_8MA);
                pad_cfg[p][i].drive         = s_r.drive[p][i];
                // R09 isolated analog path
                pad_cfg[p][i].iso_analog    = ~s_r.digital_enable_bit[p][i] &
                                              s_r.analog_mode_select_bit[p][i];
                // R10 comparator path needs digital enable clear only
                pad_cfg[p][i].direct_analog = ~s_r.digital_enable_bit[p][i];
            end
        end
    end

    assign periph_in = din;
    assign pin_out   = s_r.pin_out;
    assign pin_oe    = s_r.pin_oe;
    assign bus_rdata = s_r.rdata;
    assign adc_trig  = s_r.adc_trig;
    // R03 mask gates status onto the interrupt line
    assign irq       = |(s_r.status & s_r.mask);
endmodule

// ---- design/gpio_pkg.sv ----
// Constants, types and reset values for the GPIO pin function block
// ----------------------------------------------------------------------
// Operation
// R01: The logic is split into eight identical port blocks, A to H.
// R02: A GPIO output pin can change its level every two clock cycles.
// R03: Every pin interrupt has its own mask, apart from its detection.
// R04: Edge detection fires on rising, falling or both edges by choice.
// R05: Detection may instead be level based, on high or on low input.
// R06: Address lines give a bit mask for data reads and data writes.
// R07: Port events can raise a trigger that starts an ADC sequence.
// R08: Drive is 2, 4 or 8 mA per pin; 18 mA is held to four pads.
// R09: Isolated analog input needs digital enable clear, analog set.
// R10: Comparator pins go analog just by clearing digital enable.
// R11: A peripheral is routed only with alt select, digital enable, code.
// R12: Function select is held and applied for each pin on its own.
// R13: After reset pins are GPIO, tri-stated, pulls off, mux code zero.
// R14: Serial, UART and two-wire pins reset as alternate, code 0x1.
// R15: The four debug pins reset alternate, pulled up, code 0x3.
// R16: Power-on reset and the reset pin both restore the defaults.
// R17: With alt select clear, pin drive comes from GPIO data and dir.
// ----------------------------------------------------------------------
package gpio_pkg;
    localparam int NPORT    = 8;
    localparam int NPIN     = 8;
    localparam int CODE_W   = 4;
    localparam int ADDR_W   = 15;
    localparam int DATA_W   = 32;
    localparam int PORT_LSB = 12;
    localparam int MASK_LSB = 2;

    localparam logic [6:0] MAX_HI_DRIVE = 7'h04;

    // Byte offsets inside one port window
    localparam logic [11:0] OFF_DIR    = 12'h400;
    localparam logic [11:0] OFF_SENSE  = 12'h404;
    localparam logic [11:0] OFF_BOTH   = 12'h408;
    localparam logic [11:0] OFF_EVSEL  = 12'h40c;
    localparam logic [11:0] OFF_MASK   = 12'h410;
    localparam logic [11:0] OFF_STATUS = 12'h414;
    localparam logic [11:0] OFF_MSTAT  = 12'h418;
    localparam logic [11:0] OFF_AFSEL  = 12'h420;
    localparam logic [11:0] OFF_DRIVE  = 12'h500;
    localparam logic [11:0] OFF_ODR    = 12'h50c;
    localparam logic [11:0] OFF_PUR    = 12'h510;
    localparam logic [11:0] OFF_PDR    = 12'h514;
    localparam logic [11:0] OFF_SLR    = 12'h518;
    localparam logic [11:0] OFF_DEN    = 12'h51c;
    localparam logic [11:0] OFF_ANALOG_MODE_SELECT_BIT  = 12'h528;
    localparam logic [11:0] OFF_PCTL   = 12'h52c;
    localparam logic [11:0] OFF_ADCEN  = 12'h530;

    typedef enum logic [1:0] {
        DRV_2MA,
        DRV_4MA,
        DRV_8MA,
        DRV_18MA
    } drv_e;

    typedef struct packed {
        logic pull_up;
        logic pull_down;
        logic open_drain;
        logic slew_ctl;
        drv_e drive;
        logic iso_analog;
        logic direct_analog;
    } pad_cfg_s;

    typedef logic [NPORT-1:0][NPIN-1:0]             pin_map_t;
    typedef drv_e [NPORT-1:0][NPIN-1:0]             drv_map_t;
    typedef logic [NPORT-1:0][NPIN-1:0][CODE_W-1:0] code_map_t;
    typedef pad_cfg_s [NPORT-1:0][NPIN-1:0]         pad_map_t;

    localparam logic [CODE_W-1:0] MUX_SERIAL = 4'h1;
    localparam logic [CODE_W-1:0] MUX_DEBUG  = 4'h3;

    localparam pin_map_t AFSEL_RST = 64'h0000_0000_000f_0c3f;
    localparam pin_map_t DEN_RST   = AFSEL_RST;
    localparam pin_map_t PUR_RST   = 64'h0000_0000_000f_0000;

    // Debug pins are the only pulled-up defaults, so they pick the code
    function automatic code_map_t pctl_reset();
        code_map_t c;
        c = '0;
        for (int p = 0; p < NPORT; p++) begin
            for (int i = 0; i < NPIN; i++) begin
                if (AFSEL_RST[p][i]) begin
                    c[p][i] = PUR_RST[p][i] ? MUX_DEBUG : MUX_SERIAL;
                end
            end
        end
        return c;
    endfunction

    localparam code_map_t PCTL_RST = pctl_reset();
endpackage

// ---- design/gpio_irq_detect.sv ----
// Edge and level event detection for the pins of one port
module gpio_irq_detect #(
    parameter int NPIN = 8
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic [NPIN-1:0] level_in,
    input  wire logic [NPIN-1:0] sense,
    input  wire logic [NPIN-1:0] both,
    input  wire logic [NPIN-1:0] evsel,
    output logic      [NPIN-1:0] evt
);
    typedef struct packed {
        logic [NPIN-1:0] prev;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;
    logic [NPIN-1:0] edge_hit;
    logic [NPIN-1:0] level_hit;

    always_comb begin
        s_nxt.prev = level_in;
        rise       = level_in & ~s_r.prev;
        fall       = ~level_in & s_r.prev;
        // R04 edge choice
        edge_hit   = (both & (rise | fall)) |
                     (~both & evsel & rise) |
                     (~both & ~evsel & fall);
        // R05 level choice
        level_hit  = (evsel & level_in) | (~evsel & ~level_in);
        evt        = (sense & level_hit) | (~sense & edge_hit);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ---- test/gpio_pin_function_config_assertions.sv ----
// Port assertions for the GPIO block
module gpio_pin_function_config_assertions (
    input wire logic                        clk,
    input wire logic                        sys_rst,
    input wire logic [gpio_pkg::ADDR_W-1:0] bus_addr,
    input wire logic                        bus_wr,
    input wire logic                        bus_rd,
    input wire logic [gpio_pkg::DATA_W-1:0] bus_rdata,
    input wire gpio_pkg::pin_map_t          pin_in,
    input wire gpio_pkg::pin_map_t          pin_oe,
    input wire gpio_pkg::pin_map_t          periph_in,
    input wire gpio_pkg::code_map_t         alt_code,
    input wire gpio_pkg::pad_map_t          pad_cfg,
    input wire logic                        irq,
    input wire logic                        adc_trig
);
    timeunit 1ns;
    timeprecision 1ps;
    gpio_pkg::pin_map_t den_m;
    gpio_pkg::pin_map_t den_q;
    logic [31:0]        rd_mask;
    logic               bad_code;
    logic               bad_iso;
    int                 hi_cnt;

    always_comb begin
        bad_code = 1'b0;
        bad_iso  = 1'b0;
        hi_cnt   = 0;
        for (int p = 0; p < 64; p++) begin
            den_m[p/8][p%8] = !pad_cfg[p/8][p%8].direct_analog;
            bad_code |= alt_code[p/8][p%8] != 4'h0
                        && pad_cfg[p/8][p%8].direct_analog;
            bad_iso  |= pad_cfg[p/8][p%8].iso_analog
                        && !pad_cfg[p/8][p%8].direct_analog;
            hi_cnt += int'(pad_cfg[p/8][p%8].drive == gpio_pkg::DRV_18MA);
        end
    end

    // Enable is registered a cycle late
    always_ff @(posedge clk) begin
        den_q   <= den_m;
        rd_mask <= {24'h0, bus_addr[9:2]};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_rdata_idle: assert property (
        bus_rdata != 32'h0 |-> $past(bus_rd))
        else $error("stray read data");
    chk_data_mask: assert property (
        bus_rd && bus_addr[11:10] == 2'b00 |=> (bus_rdata & ~rd_mask) == 0)
        else $error("masked bits read");
    chk_code_gate: assert property (!bad_code)
        else $error("code on disabled pin");
    chk_iso_gate: assert property (!bad_iso)
        else $error("analog on enabled pin");
    chk_input_gate: assert property (periph_in == (pin_in & den_m))
        else $error("input not gated");
    chk_oe_den: assert property ((pin_oe & ~den_q) == '0)
        else $error("drive without enable");
    chk_drive_cap: assert property (hi_cnt <= 4)
        else $error("too many 18 mA pads");
    chk_irq_sticky: assert property ($fell(irq) |-> $past(bus_wr))
        else $error("irq fell unasked");

    cover property (adc_trig);
    cover property (irq ##1 !irq);
    cover property (bus_rd ##1 bus_rdata != 32'h0);
endmodule

// ---- test/gpio_pad_model.sv ----
// Pad and peripheral model
module gpio_pad_model (
    input  wire gpio_pkg::pin_map_t pin_out,
    input  wire gpio_pkg::pin_map_t pin_oe,
    input  wire gpio_pkg::pin_map_t ext_lvl,
    output gpio_pkg::pin_map_t      pin_in,
    output gpio_pkg::pin_map_t      alt_out,
    output gpio_pkg::pin_map_t      alt_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Device drive wins over the outside
    assign pin_in  = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
    // Block decides if peripherals reach pad
    assign alt_out = ~ext_lvl;
    assign alt_oe  = '1;
endmodule

// ---- test/test_gpio_pin_function_config.sv ----
// Self-checking GPIO bench
module test_gpio_pin_function_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic [14:0]         bus_addr = '0;
    logic [31:0]         bus_wdata = '0;
    logic                bus_wr = 1'b0;
    logic                bus_rd = 1'b0;
    logic [31:0]         bus_rdata;
    logic                irq;
    logic                adc_trig;
    gpio_pkg::pin_map_t  pin_in, pin_out, pin_oe, alt_out, alt_oe, periph_in;
    gpio_pkg::pin_map_t  ext_lvl = '0;
    gpio_pkg::code_map_t alt_code;
    gpio_pkg::pad_map_t  pad_cfg;
    int                  fails = 0;
    int                  checks = 0;
    int                  trigs = 0;
    logic [7:0]          af_e[8] = '{8'h3f, 8'h0c, 8'h0f, 0, 0, 0, 0, 0};
    // {mask, level, both, high}, start, end, event
    logic [6:0]          ev_tab[7] = '{7'b1001_011, 7'b1001_100,
        7'b1000_101, 7'b1010_011, 7'b0001_011, 7'b1101_011, 7'b1100_101};

    gpio_pin_function_config gpio_pin_function_config_i (
        .clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .pin_in, .pin_out, .pin_oe, .alt_out, .alt_oe,
        .periph_in, .alt_code, .pad_cfg, .irq, .adc_trig);
    gpio_pad_model gpio_pad_model_i (.pin_out, .pin_oe, .ext_lvl,
        .pin_in, .alt_out, .alt_oe);

    always #20 clk = ~clk;
    always @(negedge clk) trigs += int'(adc_trig === 1'b1);

    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(int p, logic [11:0] off, logic [31:0] d);
        bus_wr    <= 1'b1;
        bus_addr  <= {p[2:0], off};
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(string n, int p, logic [11:0] off, logic [31:0] e);
        bus_rd   <= 1'b1;
        bus_addr <= {p[2:0], off};
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        cmp(n, e, bus_rdata);
        @(posedge clk);
    endtask

    task automatic rst();
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic defaults();
        logic [31:0] code;
        for (int p = 0; p < 8; p++) begin
            code = '0;
            for (int i = 0; i < 8; i++)
                if (af_e[p][i]) code[4*i +: 4] = (p == 2) ? 4'h3 : 4'h1;
            rd("afsel", p, 12'h420, {24'h0, af_e[p]});
            rd("den", p, 12'h51c, {24'h0, af_e[p]});
            rd("pur", p, 12'h510, p == 2 ? {24'h0, af_e[p]} : 32'h0);
            rd("pdr", p, 12'h514, 32'h0);
            rd("pctl", p, 12'h52c, code);
        end
    endtask

    task automatic irq_case(logic [6:0] t);
        ext_lvl[6][0] <= t[2];
        wr(6, 12'h404, {31'h0, t[5]});
        wr(6, 12'h408, {31'h0, t[4]});
        wr(6, 12'h40c, {31'h0, t[3]});
        wr(6, 12'h410, {31'h0, t[6]});
        wr(6, 12'h414, 32'hff);
        ext_lvl[6][0] <= t[1];
        repeat (3) @(posedge clk);
        rd("status", 6, 12'h414, {31'h0, t[0]});
        @(negedge clk);
        cmp("irq", {31'h0, t[0] & t[6]}, {31'h0, irq});
        @(posedge clk);
    endtask

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #200us;
        fails++;
        results();
    end

    initial begin
        rst();
        defaults();
        @(negedge clk);
        cmp("alt_out", 32'h3f, pin_out[0]);
        cmp("alt_oe", 32'h3f, pin_oe[0]);
        cmp("code_c", 32'h3, alt_code[2][3]);
        @(posedge clk);
        wr(0, 12'h420, 32'h0);
        wr(3, 12'h510, 32'hff);
        @(negedge clk);
        cmp("gpio_out", 32'h0, pin_out[0]);
        cmp("gpio_oe", 32'h0, pin_oe[0]);
        cmp("code_off", 32'h0, alt_code[0][0]);
        @(posedge clk);
        rst();
        defaults();
        wr(3, 12'h51c, 32'hff);
        wr(3, 12'h400, 32'hff);
        fork
            for (int k = 0; k < 6; k++) wr(3, 12'h3fc, k[0] ? 32'h55 : 32'haa);
            for (int k = 0; k < 6; k++) begin
                repeat (2) @(posedge clk);
                @(negedge clk);
                cmp("toggle", k[0] ? 32'h55 : 32'haa, pin_out[3]);
            end
        join
        cmp("oe_d", 32'hff, pin_oe[3]);
        @(posedge clk);
        wr(3, 12'h03c, 32'h0a);
        rd("masked", 3, 12'h3c0, 32'h50);
        rd("whole", 3, 12'h3fc, 32'h5a);
        rd("unmapped", 3, 12'h600, 32'h0);
        ext_lvl[1] <= 8'hff;
        wr(1, 12'h51c, 32'h0);
        wr(1, 12'h528, 32'h10);
        @(negedge clk);
        cmp("iso", 32'h1, pad_cfg[1][4].iso_analog);
        cmp("direct", 32'h1, pad_cfg[1][5].direct_analog);
        cmp("in_b", 32'h0, periph_in[1]);
        cmp("code_b", 32'h0, alt_code[1][2]);
        @(posedge clk);
        wr(5, 12'h500, 32'he4e4);
        rd("drive_f", 5, 12'h500, 32'he4e4);
        wr(4, 12'h500, 32'hffff);
        rd("drive_cap", 4, 12'h500, 32'h000f);
        wr(6, 12'h51c, 32'hff);
        wr(6, 12'h530, 32'h1);
        foreach (ev_tab[c]) begin
            irq_case(ev_tab[c]);
            if (c == 0) begin
                cmp("adc_trig", 32'h1, trigs);
                wr(6, 12'h530, 32'h0);
            end
        end
        results();
    end
endmodule

bind gpio_pin_function_config gpio_pin_function_config_assertions chk_i (
    .clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd, .bus_rdata, .pin_in,
    .pin_oe, .periph_in, .alt_code, .pad_cfg, .irq, .adc_trig);
